// >>> common/sdr_pkg.sv
package sdr_pkg;
	localparam logic [2:0] ADDR_ROUTE = 3'h0;
	localparam logic [2:0] ADDR_CTL = 3'h1;
	localparam logic [2:0] ADDR_FLAG = 3'h3;
	localparam logic [2:0] ADDR_CNT_HI = 3'h4;
	localparam logic [2:0] ADDR_CNT_LO = 3'h5;
	localparam int B_UIE = 7;
	localparam int B_MODE = 6;
	localparam int B_RDL = 5;
	localparam int B_PRE = 4;
	localparam int B_FRC = 3;
	localparam int B_EN = 2;
	localparam int B_OIE = 0;
	localparam int B_ITG = 7;
	localparam int B_DRIVE_COIL_ENABLE = 6;
	localparam int B_POL = 4;
	localparam int B_UF = 7;
	localparam int B_OF = 0;
	localparam logic [7:0] CTL_MASK = 8'hf5;
	localparam logic [7:0] ROUTE_MASK = 8'hd3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] CNT_PRESET = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [8:0] DIV_FAST = 9'h03f;
	localparam logic [8:0] DIV_SLOW = 9'h1ff;
	localparam logic [1:0] CUR_ZERO = 2'h0;
	localparam logic [1:0] CUR_POS = 2'h1;
	localparam logic [1:0] CUR_NEG = 2'h3;
	typedef struct packed {
		logic [1:0] cos_cur;
		logic [1:0] sin_cur;
	} sdr_cur_t;
endpackage

// >>> rtl/sdr_core.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sdr_core (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic acc_overflow,
	output logic [7:0] rdata,
	output logic [8:1] switch_close,
	output sdr_pkg::sdr_cur_t coil_current,
	output logic converter_reset,
	output logic irq
);
	logic [7:0] route_r;
	logic [7:0] ctl_r;
	logic [15:0] cnt_r;
	logic [15:0] load_r;
	logic [8:0] pre_r;
	logic pre_sel_r;
	logic uf_r;
	logic of_r;
	logic [1:0] ov_sync_r;
	logic ov_prev_r;
	logic [7:0] rdata_nxt;
	logic [8:1] sw_nxt;
	sdr_pkg::sdr_cur_t cur_nxt;
	logic wr_route, wr_ctl, wr_flag, wr_hi, wr_lo, tick, at_zero;
	logic do_load;
	logic [15:0] new_load;
	logic [1:0] step;

	assign wr_route = wr && addr == sdr_pkg::ADDR_ROUTE;
	assign wr_ctl = wr && addr == sdr_pkg::ADDR_CTL;
	assign wr_flag = wr && addr == sdr_pkg::ADDR_FLAG;
	assign wr_hi = wr && addr == sdr_pkg::ADDR_CNT_HI;
	assign wr_lo = wr && addr == sdr_pkg::ADDR_CNT_LO;
	assign new_load = wr_hi ? {wdata, load_r[7:0]} : {load_r[15:8], wdata};
	assign step = route_r[1:0];

	// Force reload copies the load register into the counter.
	// It counts only when the same write leaves the counter enabled.
	assign do_load = wr_ctl && wdata[sdr_pkg::B_FRC] && wdata[sdr_pkg::B_EN];
	assign at_zero = cnt_r == sdr_pkg::CNT_ZERO;
	assign tick = pre_r == (pre_sel_r ? sdr_pkg::DIV_SLOW
		: sdr_pkg::DIV_FAST);

	always_ff @(posedge clock) begin
		if (reset) begin
			route_r <= 8'h00;
		end else if (wr_route) begin
			route_r <= wdata & sdr_pkg::ROUTE_MASK;
		end
	end

	// Bit 1 and the force bit are never stored.
	always_ff @(posedge clock) begin
		if (reset) begin
			ctl_r <= sdr_pkg::CTL_RESET;
		end else if (wr_ctl) begin
			ctl_r <= wdata & sdr_pkg::CTL_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			load_r <= sdr_pkg::CNT_PRESET;
		end else if (wr_hi || wr_lo) begin
			load_r <= new_load;
		end
	end

	// The division rate is only taken up at a load.
	always_ff @(posedge clock) begin
		if (reset) begin
			pre_sel_r <= 1'b0;
		end else if (do_load || ((wr_hi || wr_lo)
			&& !ctl_r[sdr_pkg::B_MODE]) || (tick && at_zero
			&& ctl_r[sdr_pkg::B_MODE])) begin
			pre_sel_r <= do_load ? wdata[sdr_pkg::B_PRE]
				: ctl_r[sdr_pkg::B_PRE];
		end
	end

	always_ff @(posedge clock) begin
		if (reset || !ctl_r[sdr_pkg::B_EN] || tick) begin
			pre_r <= 9'h000;
		end else begin
			pre_r <= pre_r + 9'h001;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_r <= sdr_pkg::CNT_PRESET;
		end else if (do_load) begin
			cnt_r <= load_r;
		end else if (!ctl_r[sdr_pkg::B_EN]) begin
			cnt_r <= sdr_pkg::CNT_PRESET;
		end else if ((wr_hi || wr_lo) && !ctl_r[sdr_pkg::B_MODE]) begin
			cnt_r <= new_load;
		end else if (tick) begin
			if (!at_zero) begin
				cnt_r <= cnt_r - 16'h0001;
			end else if (ctl_r[sdr_pkg::B_MODE]) begin
				cnt_r <= load_r;
			end
		end
	end

	// Set wins over a write-one clear.
	always_ff @(posedge clock) begin
		if (reset) begin
			uf_r <= 1'b0;
		end else if (ctl_r[sdr_pkg::B_EN] && tick
			&& cnt_r == 16'h0001) begin
			uf_r <= 1'b1;
		end else if (wr_flag && wdata[sdr_pkg::B_UF]) begin
			uf_r <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ov_sync_r <= 2'b00;
			ov_prev_r <= 1'b0;
		end else begin
			ov_sync_r <= {ov_sync_r[0], acc_overflow};
			ov_prev_r <= ov_sync_r[1];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			of_r <= 1'b0;
		end else if (ov_sync_r[1] && !ov_prev_r) begin
			of_r <= 1'b1;
		end else if (wr_flag && wdata[sdr_pkg::B_OF]) begin
			of_r <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= (uf_r && ctl_r[sdr_pkg::B_UIE])
				|| (of_r && ctl_r[sdr_pkg::B_OIE]);
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		case (addr)
			sdr_pkg::ADDR_ROUTE: rdata_nxt = route_r;
			sdr_pkg::ADDR_CTL: rdata_nxt = ctl_r;
			sdr_pkg::ADDR_FLAG: rdata_nxt = {uf_r, 6'h00, of_r};
			sdr_pkg::ADDR_CNT_HI: rdata_nxt = ctl_r[sdr_pkg::B_RDL]
				? load_r[15:8] : cnt_r[15:8];
			sdr_pkg::ADDR_CNT_LO: rdata_nxt = ctl_r[sdr_pkg::B_RDL]
				? load_r[7:0] : cnt_r[7:0];
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= rdata_nxt;
		end else begin
			rdata <= 8'h00;
		end
	end

	// Switch decode ignores drive coil enable.
	always_comb begin
		sw_nxt = 8'h00;
		if (route_r[sdr_pkg::B_ITG]) begin
			case ({step, route_r[sdr_pkg::B_POL]})
				3'h0: sw_nxt = 8'h90;
				3'h1: sw_nxt = 8'h60;
				3'h2: sw_nxt = 8'h06;
				3'h3: sw_nxt = 8'h09;
				3'h4: sw_nxt = 8'h60;
				3'h5: sw_nxt = 8'h90;
				3'h6: sw_nxt = 8'h09;
				3'h7: sw_nxt = 8'h06;
				default: sw_nxt = 8'h00;
			endcase
		end
	end

	always_comb begin
		cur_nxt = '{cos_cur: sdr_pkg::CUR_ZERO, sin_cur: sdr_pkg::CUR_ZERO};
		if (route_r[sdr_pkg::B_DRIVE_COIL_ENABLE]) begin
			case (step)
				2'h0: cur_nxt.cos_cur = sdr_pkg::CUR_POS;
				2'h1: cur_nxt.sin_cur = sdr_pkg::CUR_POS;
				2'h2: cur_nxt.cos_cur = sdr_pkg::CUR_NEG;
				default: cur_nxt.sin_cur = sdr_pkg::CUR_NEG;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			switch_close <= 8'h00;
			coil_current <= '0;
			converter_reset <= 1'b1;
		end else begin
			switch_close <= sw_nxt;
			coil_current <= cur_nxt;
			converter_reset <= !route_r[sdr_pkg::B_ITG];
		end
	end
endmodule
`default_nettype wire

// >>> verif/sdr_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sdr_properties (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [8:1] switch_close,
	input wire sdr_pkg::sdr_cur_t coil_current,
	input wire logic converter_reset,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic rw, cw, crd;
	assign rw = wr && addr == 3'h0;
	assign cw = wr && addr == 3'h1;
	assign crd = rd && addr == 3'h1;
	a_blank_open: assert property (
		converter_reset |-> switch_close == 8'h00) else $error("blank");
	a_pair_closed: assert property (
		!converter_reset |-> $countones(switch_close) == 2) else $error("pair");
	a_one_axis: assert property (
		coil_current.cos_cur == 2'h0 || coil_current.sin_cur == 2'h0)
		else $error("axis");
	a_itg_blank: assert property (
		rw && !wdata[7] |-> ##[1:3] converter_reset) else $error("reset");
	a_itg_run: assert property (
		rw && wdata[7] |-> ##[1:3] !converter_reset) else $error("run");
	a_drive_off: assert property (
		rw && !wdata[6] |-> ##[1:3] coil_current == 4'h0) else $error("drive");
	a_ctl_zeros: assert property (
		$past(crd) |-> !rdata[3] && !rdata[1]) else $error("zeros");
	a_irq_masked: assert property (
		cw && !wdata[7] && !wdata[0] |-> ##2 !irq) else $error("mask");
	cover property (rw && wdata[7]);
	cover property (irq);
	cover property ($fell(converter_reset));
endmodule
`default_nettype wire

// >>> verif/sdr_coil_model.sv
`timescale 1ns/1ns
`default_nettype none
module sdr_coil_model (
	input wire logic clock,
	input wire logic cr,
	input wire logic [8:1] sw,
	input wire logic sat,
	output logic ovf = 1'b0
);
	// The integrator only saturates while a switch pair is closed.
	always @(posedge clock) begin
		ovf <= sat && !cr && |sw;
	end
endmodule
`default_nettype wire

// >>> verif/stall_detect_routing_and_modulus_counter_test.sv
`timescale 1ns/1ns
`default_nettype none
module stall_detect_routing_and_modulus_counter_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, sat = 1'b0;
	logic ovf, cr, irq;
	logic [7:0] rdata;
	logic [8:1] sw;
	sdr_pkg::sdr_cur_t cur;
	int fail_count = 0, compares = 0;
	localparam logic [7:0] SW [8] = '{8'h90, 8'h60, 8'h06, 8'h09,
		8'h60, 8'h90, 8'h09, 8'h06};
	localparam logic [3:0] CU [4] = '{4'h4, 4'h1, 4'hc, 4'h3};
	always #4 clock = ~clock;
	sdr_core u_dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .acc_overflow(ovf), .rdata(rdata), .switch_close(sw),
		.coil_current(cur), .converter_reset(cr), .irq(irq));
	sdr_coil_model u_coil (.clock(clock), .cr(cr), .sw(sw), .sat(sat),
		.ovf(ovf));
	task automatic cmp(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 cmp(n, e, rdata);
	endtask
	task automatic s_route();
		for (int i = 0; i < 8; i++) begin
			wreg(3'h0, {2'b11, 1'b0, i[0], 2'b00, i[2:1]});
			repeat (2) @(posedge clock);
			#1 cmp("sw", SW[i], sw);
			cmp("cur", {4'h0, CU[i[2:1]]}, {4'h0, cur});
		end
		wreg(3'h0, 8'h43);
		repeat (2) @(posedge clock);
		#1 cmp("open", 8'h00, sw);
	endtask
	task automatic s_oneshot();
		rchk("preset", 3'h4, 8'hff);
		wreg(3'h1, 8'h14);
		wreg(3'h5, 8'h01);
		wreg(3'h4, 8'h00);
		repeat (300) @(posedge clock);
		rchk("slow", 3'h5, 8'h01);
		repeat (300) @(posedge clock);
		rchk("halt", 3'h5, 8'h00);
		wreg(3'h3, 8'h00);
		rchk("uf", 3'h3, 8'h80);
		wreg(3'h1, 8'h94);
		repeat (2) @(posedge clock);
		#1 cmp("irq", 8'h01, {7'h0, irq});
		wreg(3'h3, 8'h80);
		rchk("ufclr", 3'h3, 8'h00);
	endtask
	task automatic s_reload();
		wreg(3'h1, 8'h00);
		wreg(3'h1, 8'h40);
		wreg(3'h4, 8'h00);
		wreg(3'h5, 8'h03);
		rchk("held", 3'h5, 8'hff);
		wreg(3'h1, 8'h6e);
		rchk("ctl", 3'h1, 8'h64);
		rchk("load", 3'h5, 8'h03);
		repeat (300) @(posedge clock);
		wreg(3'h3, 8'h80);
		repeat (300) @(posedge clock);
		rchk("again", 3'h3, 8'h80);
	endtask
	task automatic s_ovf();
		wreg(3'h0, 8'h80);
		wreg(3'h1, 8'h01);
		wreg(3'h3, 8'h80);
		sat <= 1'b1;
		repeat (2) @(posedge clock);
		sat <= 1'b0;
		repeat (6) @(posedge clock);
		#1 cmp("oirq", 8'h01, {7'h0, irq});
		rchk("of", 3'h3, 8'h01);
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		s_route();
		s_oneshot();
		s_reload();
		s_ovf();
		end_of_test();
	end
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
endmodule
bind sdr_core sdr_properties u_props (.clock(clock), .reset(reset),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.switch_close(switch_close), .coil_current(coil_current),
	.converter_reset(converter_reset), .irq(irq));
`default_nettype wire
